// File: logic/sfs_pkg.sv
// constants and types shared by the speed feedback selector
package sfs_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int SAMPLE_US = 1000;
	localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
	localparam int TRIM_SHIFT = 3;
	// ------------------------------------------------------------
	// scaling: 16'h4000 is 100 % feedback
	// ------------------------------------------------------------
	localparam logic [15:0] FS_PCT = 16'h4000;
	localparam logic [55:0] ENC_NUM_K = 56'(64'h4000 * 64'd60 * 64'(CLK_HZ));
	localparam logic [13:0] PCT_MAX = 14'h2710;
	localparam logic [15:0] TRIM_ONE = 16'h2710;
	localparam logic [15:0] TRIM_MAX = 16'h2af8;
	localparam logic [9:0] MAG_MAX = 10'h3ff;
	// ------------------------------------------------------------
	// source codes
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_AV = 3'h0;
	localparam logic [2:0] SRC_TACH = 3'h1;
	localparam logic [2:0] SRC_ENC = 3'h2;
	localparam logic [2:0] SRC_ENC_AV = 3'h3;
	localparam logic [2:0] SRC_ENC_TACH = 3'h4;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LINES = 8'h04;
	localparam logic [7:0] REG_MAX_RPM = 8'h08;
	localparam logic [7:0] REG_AV_FULL = 8'h0c;
	localparam logic [7:0] REG_TACH_FULL = 8'h10;
	localparam logic [7:0] REG_IR = 8'h14;
	localparam logic [7:0] REG_FLD_TRIM = 8'h18;
	localparam logic [7:0] REG_FAULT_THR = 8'h1c;
	localparam logic [7:0] REG_INT_STAT = 8'h20;
	localparam logic [7:0] REG_INT_EN = 8'h24;
	localparam logic [7:0] REG_INT_CLR = 8'h28;
	localparam logic [7:0] REG_SPEED = 8'h2c;
	localparam logic [7:0] REG_ENC_SPEED = 8'h30;
	localparam logic [7:0] REG_STATUS = 8'h34;
	// ctrl fields and interrupt bits
	localparam int CTRL_QUAD = 3;
	localparam int CTRL_FAULT_SW = 4;
	localparam int CTRL_ZLOCK = 5;
	localparam int INT_SAMPLE = 0;
	localparam int INT_FAULT = 1;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [15:0] LINES_RST = 16'h0400;
	localparam logic [12:0] RPM_RST = 13'h05dc;
	localparam logic [15:0] AV_FULL_RST = 16'h4000;
	localparam logic [15:0] TACH_FULL_RST = 16'h4000;
	localparam logic [15:0] FAULT_THR_RST = 16'h0800;
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ENC = 5'b00010,
		S_AV = 5'b00100,
		S_TACH = 5'b01000,
		S_UPD = 5'b10000
	} sfs_state_t;
endpackage : sfs_pkg

// File: logic/sfs_top.sv
// speed feedback selection, encoder decoding and feedback scaling
//
// How it works
// - source code 0 always selects the internal armature-voltage feedback.
// - in pulse mode input b is direction, low reverse and high forward.
// - with quadrature enabled, the a/b phase order gives the direction.
// - the encoder line count is pulses per revolution in the speed conversion.
// - encoder speed is scaled so the full-scale rpm gives 100 % (16'h4000).
// - input a carries pulses, input b direction or the second phase.
// - mode 3 uses armature voltage as dynamic feedback, trimmed by the encoder.
// - mode 3 single-line takes the sign from armature voltage and frees input a unless locked.
// - mode 3 scales steady state by full-scale rpm, dynamics by armature full scale.
// - mode 4 uses tacho as dynamic feedback, trimmed by the encoder.
// - mode 4 single-line takes the sign from the tacho and frees input a unless locked.
// - mode 4 scales dynamics by tacho full scale, steady state by full-scale rpm.
// - a lost encoder either trips the drive or falls back to armature voltage.
// - armature voltage loses a resistive drop set by 0 to 100.00 %, default 0.
// - field feedback is multiplied by a 1.0000 to 1.1000 trim, changeable while running.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sfs_top #(
	parameter int SAMPLE_CYCLES = sfs_pkg::SAMPLE_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// encoder pins
	input wire logic encoder_terminal_a,
	input wire logic encoder_terminal_b,
	// converter samples, same clock
	input wire logic signed [15:0] armature_voltage_feedback,
	input wire logic signed [15:0] tacho_feedback,
	input wire logic signed [15:0] armature_current,
	input wire logic [15:0] field_current,
	// results
	output logic signed [15:0] speed_feedback,
	output logic [15:0] field_feedback,
	output logic drive_trip,
	output logic encoder_a_released,
	output logic encoder_a_aux,
	output logic irq
);
	import sfs_pkg::*;

	function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
		if (v > 20'sd32767) begin
			return 16'sh7fff;
		end else if (v < -20'sd32767) begin
			return -16'sh7fff;
		end
		return v[15:0];
	endfunction : sat16

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [5:0] ctrl;
	logic [15:0] enc_lines;
	logic [12:0] max_rpm;
	logic [15:0] av_full;
	logic [15:0] tach_full;
	logic [13:0] ir_comp;
	logic [15:0] field_trim;
	logic [15:0] fault_thr;
	logic [1:0] int_status;
	logic [1:0] int_enable;
	logic fb_fallback;
	logic signed [15:0] enc_speed;
	wire [2:0] src = ctrl[2:0];
	wire quad = ctrl[CTRL_QUAD];
	wire fault_sw = ctrl[CTRL_FAULT_SW];
	wire zlock = ctrl[CTRL_ZLOCK];
	wire wr_ctrl = wr_en && addr == REG_CTRL;
	wire wr_trim = wr_en && addr == REG_FLD_TRIM;
	wire wr_ir = wr_en && addr == REG_IR;
	wire [1:0] int_clr = (wr_en && addr == REG_INT_CLR) ? wr_data[1:0] : 2'h0;
	// out-of-range settings clamp rather than wrap
	wire [15:0] trim_wr = (wr_data[15:0] < TRIM_ONE) ? TRIM_ONE :
		(wr_data[15:0] > TRIM_MAX) ? TRIM_MAX : wr_data[15:0];
	wire [13:0] ir_wr = (wr_data[15:0] > {2'h0, PCT_MAX}) ? PCT_MAX : wr_data[13:0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			enc_lines <= LINES_RST;
			max_rpm <= RPM_RST;
			av_full <= AV_FULL_RST;
			tach_full <= TACH_FULL_RST;
			ir_comp <= 14'h0;
			field_trim <= TRIM_ONE;
			fault_thr <= FAULT_THR_RST;
			int_enable <= 2'h0;
		end else if (wr_en) begin
			if (wr_ctrl)
				ctrl <= wr_data[5:0];
			if (addr == REG_LINES)
				enc_lines <= wr_data[15:0];
			if (addr == REG_MAX_RPM)
				max_rpm <= wr_data[12:0];
			if (addr == REG_AV_FULL)
				av_full <= wr_data[15:0];
			if (addr == REG_TACH_FULL)
				tach_full <= wr_data[15:0];
			if (wr_ir)
				ir_comp <= ir_wr;
			if (wr_trim)
				field_trim <= trim_wr;
			if (addr == REG_FAULT_THR)
				fault_thr <= wr_data[15:0];
			if (addr == REG_INT_EN)
				int_enable <= wr_data[1:0];
		end
	end

	// ------------------------------------------------------------
	// encoder input sync and decode
	// ------------------------------------------------------------
	logic a_m, a_s, a_d, b_m, b_s, b_d;
	always_ff @(posedge mclk) begin
		if (rst) begin
			{a_m, a_s, a_d, b_m, b_s, b_d} <= 6'h00;
		end else begin
			a_m <= encoder_terminal_a;
			a_s <= a_m;
			a_d <= a_s;
			b_m <= encoder_terminal_b;
			b_s <= b_m;
			b_d <= b_s;
		end
	end

	// single-line combined modes without zlock: b is ignored, sign comes from the analog source
	wire analog_sign = (src == SRC_ENC_AV || src == SRC_ENC_TACH) && !quad && !zlock;
	wire a_rise = a_s && !a_d;
	wire q_edge = (a_s ^ a_d) ^ (b_s ^ b_d);
	wire q_fwd = !(a_d ^ b_s);
	wire signed [1:0] step = quad ? (q_edge ? (q_fwd ? 2'sd1 : -2'sd1) : 2'sd0)
		: !a_rise ? 2'sd0 : (analog_sign || b_s) ? 2'sd1 : -2'sd1;

	// ------------------------------------------------------------
	// sample window and edge count
	// ------------------------------------------------------------
	logic [31:0] samp_cnt;
	logic signed [15:0] enc_cnt;
	wire sample_tick = samp_cnt == 32'(SAMPLE_CYCLES - 1);
	wire [15:0] cnt_abs = enc_cnt[15] ? 16'(-enc_cnt) : enc_cnt;
	// window holds at most 1023 edges; 100 kHz x4 in 1 ms is 400
	wire [9:0] mag_now = (cnt_abs > 16'(MAG_MAX)) ? MAG_MAX : cnt_abs[9:0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			samp_cnt <= 32'h0;
			enc_cnt <= 16'sh0;
		end else begin
			samp_cnt <= sample_tick ? 32'h0 : samp_cnt + 32'h1;
			enc_cnt <= sample_tick ? 16'(step) : enc_cnt + 16'(step);
		end
	end

	// ------------------------------------------------------------
	// shared divider: encoder, armature voltage, tacho in turn
	// ------------------------------------------------------------
	sfs_state_t state, next_state;
	logic [55:0] div_num, div_q;
	logic [47:0] div_den;
	logic [48:0] div_rem;
	logic [5:0] div_bit;
	logic enc_neg, av_neg, tach_neg;
	logic [9:0] enc_mag;
	logic [15:0] av_mag, tach_mag, res_enc, res_av, res_tach;
	wire busy = state == S_ENC || state == S_AV || state == S_TACH;
	wire div_done = busy && div_bit == 6'h37;
	wire [48:0] rem_sh = {div_rem[47:0], div_num[55]};
	wire rem_ge = rem_sh >= {1'b0, div_den};
	wire [48:0] next_rem = rem_ge ? rem_sh - {1'b0, div_den} : rem_sh;
	wire [55:0] next_q = {div_q[54:0], rem_ge};
	wire [15:0] q_sat = (|next_q[55:15]) ? 16'h7fff : next_q[15:0];
	wire [15:0] av_abs = armature_voltage_feedback[15] ?
		16'(-armature_voltage_feedback) : armature_voltage_feedback;
	wire [15:0] tach_abs = tacho_feedback[15] ? 16'(-tacho_feedback) : tacho_feedback;
	// lines per rev times rpm times window; quadrature yields four edges per line
	wire [47:0] enc_den = (48'(enc_lines) * 48'(max_rpm) * 48'(SAMPLE_CYCLES))
		<< (quad ? 2 : 0);
	wire [55:0] enc_num = 56'(mag_now) * ENC_NUM_K;
	wire div_load = (state == S_IDLE && sample_tick) || (div_done && state != S_TACH);
	wire [55:0] ld_num = (state == S_IDLE) ? enc_num :
		(state == S_ENC) ? {24'h0, av_mag, 16'h0} >> 2 : {24'h0, tach_mag, 16'h0} >> 2;
	wire [47:0] ld_den = (state == S_IDLE) ? enc_den :
		(state == S_ENC) ? 48'(av_full) : 48'(tach_full);
	wire enc_sign_now = analog_sign ? (src == SRC_ENC_AV ? armature_voltage_feedback[15]
		: tacho_feedback[15]) : enc_cnt[15];

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (sample_tick) next_state = S_ENC;
			S_ENC: if (div_done) next_state = S_AV;
			S_AV: if (div_done) next_state = S_TACH;
			S_TACH: if (div_done) next_state = S_UPD;
			S_UPD: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= S_IDLE;
			{div_num, div_q} <= 112'h0;
			div_den <= 48'h0;
			div_rem <= 49'h0;
			div_bit <= 6'h0;
		end else begin
			state <= next_state;
			if (div_load) begin
				div_num <= ld_num;
				div_den <= ld_den;
				div_rem <= 49'h0;
				div_q <= 56'h0;
				div_bit <= 6'h0;
			end else if (busy) begin
				div_num <= {div_num[54:0], 1'b0};
				div_rem <= next_rem;
				div_q <= next_q;
				div_bit <= div_bit + 6'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			{enc_neg, av_neg, tach_neg} <= 3'h0;
			enc_mag <= 10'h0;
			{av_mag, tach_mag} <= 32'h0;
			{res_enc, res_av, res_tach} <= 48'h0;
		end else begin
			if (state == S_IDLE && sample_tick) begin
				enc_neg <= enc_sign_now;
				enc_mag <= mag_now;
				av_neg <= armature_voltage_feedback[15];
				tach_neg <= tacho_feedback[15];
				av_mag <= av_abs;
				tach_mag <= tach_abs;
			end
			if (div_done && state == S_ENC)
				res_enc <= q_sat;
			if (div_done && state == S_AV)
				res_av <= q_sat;
			if (div_done && state == S_TACH)
				res_tach <= q_sat;
		end
	end

	// ------------------------------------------------------------
	// feedback combination
	// ------------------------------------------------------------
	logic signed [15:0] trim_acc;
	wire signed [31:0] drop_full = armature_current * $signed({18'h0, ir_comp});
	wire signed [31:0] drop = drop_full / 32'sd10000;
	wire signed [19:0] av_pct = av_neg ? -20'(res_av) : 20'(res_av);
	wire signed [15:0] av_fb = sat16(av_pct - 20'(drop));
	wire signed [15:0] tach_fb = tach_neg ? -$signed(res_tach) : $signed(res_tach);
	wire signed [15:0] enc_fb = enc_neg ? -$signed(res_enc) : $signed(res_enc);
	wire signed [15:0] dyn_fb = (src == SRC_ENC_AV) ? av_fb : tach_fb;
	wire signed [15:0] comb_fb = sat16(20'(dyn_fb) + 20'(trim_acc));
	wire signed [19:0] trim_err = (20'(enc_fb) - 20'(comb_fb)) >>> TRIM_SHIFT;
	wire signed [15:0] next_trim = sat16(20'(trim_acc) + trim_err);
	wire [2:0] act_src = (fb_fallback || src > SRC_ENC_TACH) ? SRC_AV : src;
	wire signed [15:0] next_speed = (act_src == SRC_AV) ? av_fb :
		(act_src == SRC_TACH) ? tach_fb : (act_src == SRC_ENC) ? enc_fb : comb_fb;
	wire uses_enc = act_src == SRC_ENC || act_src == SRC_ENC_AV || act_src == SRC_ENC_TACH;
	wire av_big = (av_fb[15] ? 16'(-av_fb) : av_fb) > fault_thr;
	wire fault_evt = state == S_UPD && uses_enc && enc_mag == 10'h0 && av_big;
	wire [31:0] fld_prod = 32'(field_current) * 32'(field_trim);
	wire [31:0] fld_q = fld_prod / 32'd10000;
	wire [1:0] int_evt = {fault_evt, state == S_UPD};

	always_ff @(posedge mclk) begin
		if (rst) begin
			speed_feedback <= 16'sh0;
			enc_speed <= 16'sh0;
			trim_acc <= 16'sh0;
		end else if (state == S_UPD) begin
			speed_feedback <= next_speed;
			enc_speed <= enc_fb;
			// trim only integrates while a combined mode is live
			trim_acc <= (act_src == SRC_ENC_AV || act_src == SRC_ENC_TACH) ? next_trim
				: 16'sh0;
		end
	end

	// ------------------------------------------------------------
	// fault, interrupts, pin outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			drive_trip <= 1'b0;
			fb_fallback <= 1'b0;
			int_status <= 2'h0;
			irq <= 1'b0;
			field_feedback <= 16'h0;
			encoder_a_released <= 1'b0;
			encoder_a_aux <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			drive_trip <= (drive_trip && !int_clr[INT_FAULT]) || (fault_evt && !fault_sw);
			fb_fallback <= (fb_fallback && !int_clr[INT_FAULT]) || (fault_evt && fault_sw);
			int_status <= (int_status & ~int_clr) | int_evt;
			irq <= |(int_status & int_enable);
			field_feedback <= (|fld_q[31:16]) ? 16'hffff : fld_q[15:0];
			encoder_a_released <= analog_sign;
			encoder_a_aux <= a_s;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	wire [31:0] rd_mux =
		(addr == REG_CTRL) ? {26'h0, ctrl} :
		(addr == REG_LINES) ? {16'h0, enc_lines} :
		(addr == REG_MAX_RPM) ? {19'h0, max_rpm} :
		(addr == REG_AV_FULL) ? {16'h0, av_full} :
		(addr == REG_TACH_FULL) ? {16'h0, tach_full} :
		(addr == REG_IR) ? {18'h0, ir_comp} :
		(addr == REG_FLD_TRIM) ? {16'h0, field_trim} :
		(addr == REG_FAULT_THR) ? {16'h0, fault_thr} :
		(addr == REG_INT_STAT) ? {30'h0, int_status} :
		(addr == REG_INT_EN) ? {30'h0, int_enable} :
		(addr == REG_SPEED) ? 32'(speed_feedback) :
		(addr == REG_ENC_SPEED) ? 32'(enc_speed) :
		(addr == REG_STATUS) ? {24'h0, encoder_a_released, act_src, 2'h0, fb_fallback,
			drive_trip} : 32'h0;

	always_ff @(posedge mclk) begin
		if (rst)
			rd_data <= 32'h0;
		else
			rd_data <= rd_en ? rd_mux : 32'h0;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_fallback_src;
		@(posedge mclk) disable iff (rst) fb_fallback |-> act_src == SRC_AV;
	endproperty
	a_fallback_src: assert property (p_fallback_src) else $error("fallback not on av");
	property p_switch;
		@(posedge mclk) disable iff (rst) fault_evt && fault_sw |=> fb_fallback && !drive_trip;
	endproperty
	a_switch: assert property (p_switch) else $error("fault did not switch source");
	property p_trip;
		@(posedge mclk) disable iff (rst) fault_evt && !fault_sw |=> drive_trip;
	endproperty
	a_trip: assert property (p_trip) else $error("fault did not trip");
	property p_pulse_rev;
		@(posedge mclk) disable iff (rst)
		!quad && !analog_sign && a_rise && !b_s && !sample_tick |=> enc_cnt == $past(enc_cnt) - 16'sh1;
	endproperty
	a_pulse_rev: assert property (p_pulse_rev) else $error("low direction not reverse");
	property p_quad_fwd;
		@(posedge mclk) disable iff (rst)
		quad && q_edge && q_fwd && !sample_tick |=> enc_cnt == $past(enc_cnt) + 16'sh1;
	endproperty
	a_quad_fwd: assert property (p_quad_fwd) else $error("quadrature forward miscount");
	property p_release;
		@(posedge mclk) disable iff (rst)
		src == SRC_ENC_AV && !quad && !zlock |=> encoder_a_released;
	endproperty
	a_release: assert property (p_release) else $error("input a not released");
	property p_no_release;
		@(posedge mclk) disable iff (rst) zlock ##1 zlock |-> !encoder_a_released;
	endproperty
	a_no_release: assert property (p_no_release) else $error("released under lock");
	property p_trim_range;
		@(posedge mclk) disable iff (rst) field_trim >= TRIM_ONE && field_trim <= TRIM_MAX;
	endproperty
	a_trim_range: assert property (p_trim_range) else $error("field trim out of range");
	property p_ir_range;
		@(posedge mclk) disable iff (rst) wr_ir |=> ir_comp <= PCT_MAX;
	endproperty
	a_ir_range: assert property (p_ir_range) else $error("resistive_drop_correction too big");
	property p_div_len;
		@(posedge mclk) disable iff (rst)
		state == S_ENC && $past(state) == S_IDLE |-> ##56 state == S_AV;
	endproperty
	a_div_len: assert property (p_div_len) else $error("encoder divide length wrong");
	property p_rd_speed;
		@(posedge mclk) disable iff (rst)
		rd_en && addr == REG_SPEED |=> rd_data == 32'($past(speed_feedback));
	endproperty
	a_rd_speed: assert property (p_rd_speed) else $error("speed readback wrong");
	c_mode3: cover property (@(posedge mclk) disable iff (rst) state == S_UPD && act_src == SRC_ENC_AV);
	c_mode4: cover property (@(posedge mclk) disable iff (rst) state == S_UPD && act_src == SRC_ENC_TACH);
	c_fallback: cover property (@(posedge mclk) disable iff (rst) fault_evt && fault_sw);
	c_irq: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
endmodule : sfs_top

// File: tb/sfs_enc_model.sv
// encoder stand-in for the speed feedback selector bench
`timescale 1ns/1ps
module sfs_enc_model #(
	parameter int QUARTER = 100
) (
	// control
	input wire logic mclk,
	input wire logic run,
	input wire logic quad,
	input wire logic fwd,
	// encoder lines
	output logic enc_a,
	output logic enc_b
);
	// ----
	// shaft position
	// ----
	// line period 4*QUARTER cycles, 100 kHz: no faster than the decoder takes
	int cnt = 0;
	logic [1:0] ph = 2'h0;
	always @(posedge mclk) begin
		if (run) begin
			cnt <= (cnt == QUARTER - 1) ? 0 : cnt + 1;
			if (cnt == QUARTER - 1) begin
				ph <= fwd ? ph + 2'h1 : ph - 2'h1;
			end
		end
	end
	// a leads b when turning forward; a stopped shaft holds its lines
	assign enc_a = ph[1] ^ ph[0];
	assign enc_b = quad ? ph[1] : fwd;
endmodule : sfs_enc_model

// File: tb/tb.sv
// self-checking bench for the speed feedback selector
`timescale 1ns/1ps
module tb;
	import sfs_pkg::*;
	// short window keeps the run small; expectations assume 4000
	localparam int SAMP = 4000;
	// two whole windows plus the update latency after a change
	localparam int SPAN = 2 * SAMP + 200;
	localparam logic [7:0] RA[9] = '{REG_CTRL, REG_LINES, REG_MAX_RPM, REG_AV_FULL,
		REG_TACH_FULL, REG_IR, REG_FLD_TRIM, REG_FAULT_THR, REG_INT_EN};
	localparam logic [31:0] RV[9] = '{32'h0, 32'h400, 32'h5dc, 32'h4000, 32'h4000,
		32'h0, 32'h2710, 32'h800, 32'h0};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic enc_a;
	logic enc_b;
	logic run = 1'b0;
	logic quad = 1'b0;
	logic fwd = 1'b1;
	logic signed [15:0] av = 16'sh0;
	logic signed [15:0] tach = 16'sh0;
	logic signed [15:0] cur = 16'sh0;
	logic [15:0] fld = 16'h0;
	logic signed [15:0] speed;
	logic [15:0] fld_fb;
	logic trip;
	logic released;
	logic aux;
	logic irq;
	logic rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	int fails = 0;
	int compares = 0;
	int unsigned r;

	sfs_enc_model i_sfs_enc_model (.mclk(mclk), .run(run), .quad(quad), .fwd(fwd),
		.enc_a(enc_a), .enc_b(enc_b));
	sfs_top #(.SAMPLE_CYCLES(SAMP)) i_sfs_top (.mclk(mclk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.encoder_terminal_a(enc_a), .encoder_terminal_b(enc_b),
		.armature_voltage_feedback(av), .tacho_feedback(tach), .armature_current(cur),
		.field_current(fld), .speed_feedback(speed), .field_feedback(fld_fb),
		.drive_trip(trip), .encoder_a_released(released), .encoder_a_aux(aux), .irq(irq));

	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// ----
	// helpers
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk);
		rd_en <= 1'b0;
	endtask : rd
	// ends on a falling edge, where outputs are settled
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask : settle
	function automatic logic [31:0] fexp(input logic [15:0] f, input int unsigned t);
		int unsigned v;
		v = f * t / 10000;
		return (v > 32'hffff) ? 32'hffff : v;
	endfunction : fexp
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// ----
	// read data watcher: the oldest note pairs with each answer
	// ----
	always @(posedge mclk) rd_pend <= rd_en;
	always @(negedge mclk) begin
		if (rd_pend) begin
			check(rd_data, exp_q.pop_front());
		end
	end
	initial begin
		repeat (96000) @(posedge mclk);
		fails++;
		conclude();
	end
	// ----
	// scenarios
	// ----
	initial begin
		r = $urandom(97705);
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		foreach (RA[i]) rd(RA[i], RV[i]);
		rd(8'h3c, 32'h0);
		wr(REG_SPEED, 32'h1234);
		rd(REG_SPEED, 32'h0);
		wr(REG_FLD_TRIM, 32'h2ee0);
		rd(REG_FLD_TRIM, 32'h2af8);
		fld <= 16'($urandom);
		settle(3);
		check({16'h0, fld_fb}, fexp(fld, 11000));
		wr(REG_FLD_TRIM, 32'h1388);
		rd(REG_FLD_TRIM, 32'h2710);
		fld <= 16'($urandom);
		settle(3);
		check({16'h0, fld_fb}, {16'h0, fld});
		// 10 pulses a window, 40 quadrature edges, at 1000 lines and 6000 rpm give full scale
		wr(REG_LINES, 32'h3e8);
		wr(REG_MAX_RPM, 32'h1770);
		run <= 1'b1;
		for (int q = 0; q < 2; q++) begin
			wr(REG_CTRL, q ? 32'ha : 32'h2);
			quad <= q[0];
			for (int d = 1; d >= 0; d--) begin
				@(posedge mclk);
				fwd <= d[0];
				settle(SPAN);
				check({16'h0, speed}, d ? 32'h4000 : 32'hc000);
			end
		end
		rd(REG_ENC_SPEED, 32'hffffc000);
		wr(REG_CTRL, 32'h0);
		// single-line forward well ahead, so the first combined window is clean
		quad <= 1'b0;
		fwd <= 1'b1;
		wr(REG_IR, 32'h1388);
		av <= 16'sh2000;
		cur <= 16'sh1000;
		settle(SPAN);
		check({16'h0, speed}, 32'h1800);
		wr(REG_IR, 32'h4e20);
		rd(REG_IR, 32'h2710);
		wr(REG_IR, 32'h0);
		av <= -16'sh4000;
		tach <= -16'sh4000;
		for (int m = 3; m < 5; m++) begin
			wr(REG_CTRL, 32'(m));
			settle(SPAN);
			check({16'h0, speed}, 32'hc000);
			check({31'h0, released}, 32'h1);
			wr(REG_CTRL, 32'(m) | 32'h20);
			settle(3);
			check({31'h0, released}, 32'h0);
		end
		wr(REG_CTRL, 32'h1);
		settle(SPAN);
		check({16'h0, speed}, 32'hc000);
		wr(REG_CTRL, 32'h2);
		wr(REG_INT_EN, 32'h2);
		run <= 1'b0;
		av <= 16'sh2000;
		settle(SPAN);
		check({31'h0, trip}, 32'h1);
		check({31'h0, aux}, {31'h0, enc_a});
		check({31'h0, irq}, 32'h1);
		wr(REG_INT_EN, 32'h0);
		settle(3);
		check({31'h0, irq}, 32'h0);
		wr(REG_INT_EN, 32'h2);
		settle(3);
		check({31'h0, irq}, 32'h1);
		wr(REG_CTRL, 32'h0);
		wr(REG_INT_CLR, 32'h2);
		settle(3);
		check({30'h0, trip, irq}, 32'h0);
		wr(REG_INT_CLR, 32'h3);
		wr(REG_CTRL, 32'h12);
		settle(SPAN);
		check({15'h0, trip, speed}, 32'h2000);
		rd(REG_INT_STAT, 32'h3);
		conclude();
	end
endmodule : tb
